// [include/ptt_pkg.sv]
// shared constants, register map and types of the periodic tick timer
package ptt_pkg;

  // counter and tap layout
  localparam int CNT_W  = 8;
  localparam int FLAG_W = 4;
  localparam int TAP_32 = 2;
  localparam int TAP_8  = 4;
  localparam int TAP_2  = 6;
  localparam int TAP_1  = 7;

  // register indices; byte address is four times the index
  localparam int          IDX_W   = 2;
  localparam logic [1:0]  IDX_CTL = 2'h0;
  localparam logic [1:0]  IDX_CNT = 2'h1;
  localparam logic [1:0]  IDX_EN  = 2'h2;
  localparam logic [1:0]  IDX_FLG = 2'h3;
  localparam int          BYTE_SH = 2;

  // field positions
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_CLR_BIT = 4;
  localparam int FLG_32_BIT  = 3;
  localparam int FLG_8_BIT   = 2;
  localparam int FLG_2_BIT   = 1;
  localparam int FLG_1_BIT   = 0;

  // reset values
  localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ST_STOPPED = 2'b00,
    ST_RUN     = 2'b01,
    ST_LAST    = 2'b10
  } ptt_run_type;

  // register index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [7:0] addr);
    reg_index = addr[BYTE_SH+IDX_W-1:BYTE_SH];
  endfunction

  // address lies inside the four-word map
  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr[7:BYTE_SH+IDX_W] == 4'h0);
  endfunction

endpackage

// [include/ptt_cnt_if.sv]
// link between the register side and the tick counter core
`timescale 1ns/1ps
interface ptt_cnt_if import ptt_pkg::*; ();
  logic              tick_lvl;
  logic              clr;
  logic              run_req;
  logic [CNT_W-1:0]  count;
  logic              busy;
  logic [FLAG_W-1:0] evt;

  modport ctrl (output tick_lvl, output clr, output run_req, input count, input busy, input evt);
  modport core (input tick_lvl, input clr, input run_req, output count, output busy, output evt);
endinterface

// [src/ptt_counter.sv]
// 8-bit tick counter with run/stop sequencing and tap falling-edge events
`timescale 1ns/1ps
module ptt_counter import ptt_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and status
  ptt_cnt_if.core  cif
);

  logic              tick_d_r;
  logic              rise;
  logic              fall;
  logic              cnt_edge;
  logic              inc;
  logic [CNT_W-1:0]  count_r;
  logic [FLAG_W-1:0] evt_r;
  ptt_run_type       state_r;
  ptt_run_type       state_nxt;

  // taps that fall when the counter steps from c
  function automatic logic [FLAG_W-1:0] tap_falls(input logic [CNT_W-1:0] c);
    tap_falls = {&c[TAP_32:0], &c[TAP_8:0], &c[TAP_2:0], &c[TAP_1:0]};
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_d_r <= 1'b0;
    else
      tick_d_r <= cif.tick_lvl;
  end

  assign rise     = cif.tick_lvl & ~tick_d_r;
  assign fall     = ~cif.tick_lvl & tick_d_r;
  assign cnt_edge = rise & (state_r != ST_STOPPED);
  assign inc      = cnt_edge & ~cif.clr;

  // run and stop take effect on the falling edge of the count clock
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STOPPED: if (fall && cif.run_req) state_nxt = ST_RUN;
      ST_RUN:     if (fall && !cif.run_req) state_nxt = ST_LAST;
      ST_LAST:
      begin
        if (fall && cif.run_req)
          state_nxt = ST_RUN;
        else if (cnt_edge)
          state_nxt = ST_STOPPED;
      end
      default:    state_nxt = ST_STOPPED;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= ST_STOPPED;
    else
      state_r <= state_nxt;
  end

  // clear beats a same-cycle step; stopped count holds
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= CNT_RST;
    else if (cif.clr)
      count_r <= CNT_RST;
    else if (inc)
      count_r <= count_r + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_r <= FLAG_RST;
    else
      evt_r <= inc ? tap_falls(count_r) : FLAG_RST;
  end

  assign cif.count = count_r;
  assign cif.busy  = (state_r != ST_STOPPED);
  assign cif.evt   = evt_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_clear_zeroes: assert property (cif.clr |=> count_r == CNT_RST)
    else $error("counter not zero after clear");
  a_count_step: assert property (inc |=> count_r == $past(count_r) + 8'h01)
    else $error("counter did not step by one");
  a_stop_holds: assert property ((state_r == ST_STOPPED && !cif.clr) |=> $stable(count_r))
    else $error("stopped counter changed");
  a_start_on_fall: assert property ((state_r == ST_STOPPED && cif.run_req && fall) |=> state_r == ST_RUN)
    else $error("run not started on falling edge");
  a_extra_count: assert property ((state_r == ST_RUN && !cif.run_req && fall) |=> state_r == ST_LAST)
    else $error("stop skipped the last count");
  a_wrap_zero: assert property ((inc && count_r == 8'hFF) |=> count_r == CNT_RST)
    else $error("counter did not wrap");

  c_last_stop: cover property (state_r == ST_LAST ##[1:300] state_r == ST_STOPPED);
  c_clear_run: cover property (cif.clr && cif.run_req && state_r == ST_STOPPED);
endmodule

// [src/ptt_timer.sv]
// periodic tick timer: axi4-lite registers, interrupt flags and counter core
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
//
// Operation
// - 8-bit up-counter stepped by the 256 Hz count clock.
// - every counter bit readable, giving 128 Hz down to 1 Hz squares.
// - count bit 7 is the 1 Hz tap, bit 0 the 128 Hz tap.
// - writing one to the clear control zeroes the counter.
// - reset also zeroes the counter.
// - clear while running keeps counting; clear while stopped holds zero.
// - run control one starts counting, zero gates the count clock off.
// - stopping keeps the count so a restart continues from it.
// - run and clear written together: clear, then count.
// - start and stop happen on the next count clock falling edge.
// - after a stop request the counter steps once more, then stops.
// - run control reads one until the counter has really stopped.
// - falling 32, 8, 2 and 1 Hz taps set their own flag while counting.
// - a flag requests an interrupt only when its enable is one.
// - all four causes share one interrupt output; flags tell the cause.
// - writing one to a flag clears it; software clears before enabling.
module ptt_timer import ptt_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // 256 hz count clock from the low-speed oscillator divider
  input  wire logic        osc_tick_256hz,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // shared request toward the interrupt controller
  output logic             tick_irq
);

  ptt_cnt_if cif ();

  logic              awready_r;
  logic              wready_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              run_req_r;
  logic [FLAG_W-1:0] en_r;
  logic [FLAG_W-1:0] flg_r;
  logic              irq_r;
  logic              wr_fire;
  logic              wr_ok;
  logic [IDX_W-1:0]  wr_idx;
  logic              wr_lane;
  logic              ctl_wr;
  logic [FLAG_W-1:0] flg_clr;
  logic [FLAG_W-1:0] flg_gone;
  logic              ar_fire;
  logic [31:0]       rd_word;

  ptt_counter u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif.core)
  );

  // ---- write channels: address and data taken in either order
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_idx  = reg_index(aw_addr_r);
  assign wr_ok   = reg_mapped(aw_addr_r);
  assign wr_lane = w_strb_r[0];
  assign ctl_wr  = wr_fire & wr_ok & wr_lane & (wr_idx == IDX_CTL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end
    else if (s_axi_awvalid && awready_r)
    begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      awready_r <= 1'b1;
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_r <= 1'b1;
      w_full_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && wready_r)
    begin
      wready_r <= 1'b0;
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      wready_r <= 1'b1;
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // ---- control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_req_r <= 1'b0;
    else if (ctl_wr)
      run_req_r <= w_data_r[CTL_RUN_BIT];
  end

  // one-cycle clear pulse; a zero write leaves the counter alone
  assign cif.clr      = ctl_wr & w_data_r[CTL_CLR_BIT];
  assign cif.run_req  = run_req_r;
  assign cif.tick_lvl = osc_tick_256hz;

  // ---- enables and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      en_r <= FLAG_RST;
    else if (wr_fire && wr_ok && wr_lane && wr_idx == IDX_EN)
      en_r <= w_data_r[FLAG_W-1:0];
  end

  assign flg_clr  = (wr_fire && wr_ok && wr_lane && wr_idx == IDX_FLG) ? w_data_r[FLAG_W-1:0] : FLAG_RST;
  assign flg_gone = flg_clr & ~cif.evt;

  // a tap event in the clearing cycle keeps its flag set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flg_r <= FLAG_RST;
    else
      flg_r <= (flg_r & ~flg_clr) | cif.evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(flg_r & en_r);
  end

  // ---- read channel
  assign ar_fire = s_axi_arvalid & arready_r;

  always_comb
  begin
    rd_word = 32'h00000000;
    case (reg_index(s_axi_araddr))
      IDX_CTL: rd_word[CTL_RUN_BIT] = run_req_r | cif.busy;
      IDX_CNT: rd_word[CNT_W-1:0] = cif.count;
      IDX_EN:  rd_word[FLAG_W-1:0] = en_r;
      IDX_FLG: rd_word[FLAG_W-1:0] = flg_r;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= reg_mapped(s_axi_araddr) ? rd_word : 32'h00000000;
      rresp_r   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign tick_irq      = irq_r;

  // ---- checks
  logic ar_ctl;
  logic ar_cnt;
  logic ctl_busy_rd;

  assign ar_ctl      = ar_fire & reg_mapped(s_axi_araddr) & (reg_index(s_axi_araddr) == IDX_CTL);
  assign ar_cnt      = ar_fire & reg_mapped(s_axi_araddr) & (reg_index(s_axi_araddr) == IDX_CNT);
  assign ctl_busy_rd = ar_ctl & cif.busy;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_flag_sets: assert property ((|cif.evt) |=> ((flg_r & $past(cif.evt)) == $past(cif.evt)))
    else $error("tap event did not set its flag");
  a_flag_w1c: assert property ((|flg_gone) |=> ((flg_r & $past(flg_gone)) == FLAG_RST))
    else $error("flag not cleared by write of one");
  a_irq_masked: assert property ((en_r == FLAG_RST) |=> !irq_r)
    else $error("interrupt raised while all enables are zero");
  a_irq_shared: assert property ((|(flg_r & en_r)) |=> irq_r ##0 (|$past(flg_r)))
    else $error("enabled flag did not raise the interrupt");
  a_run_reads_one: assert property (ctl_busy_rd |=> rvalid_r && rdata_r[CTL_RUN_BIT])
    else $error("run control read zero while still counting");
  a_clear_reads_zero: assert property (ar_ctl |=> !rdata_r[CTL_CLR_BIT])
    else $error("clear control read back as one");
  a_count_read: assert property (ar_cnt |=> rdata_r[CNT_W-1:0] == $past(cif.count))
    else $error("counter read value mismatch");
  a_bresp_hold: assert property ((bvalid_r && !s_axi_bready) |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before taken");
  a_clear_run: assert property ((cif.clr && w_data_r[CTL_RUN_BIT]) |=> cif.count == CNT_RST && run_req_r)
    else $error("clear with run did not zero and arm the counter");

  c_flag_one_hz: cover property (cif.evt[FLG_1_BIT] ##1 flg_r[FLG_1_BIT]);
  c_irq_raise: cover property (!irq_r ##1 irq_r);
  c_flag_clear: cover property (|flg_gone);
endmodule

// [tb/ptt_osc_irq_model.sv]
// count clock source and interrupt controller stand-in for the tick timer
`timescale 1ns/1ps
module ptt_osc_irq_model #(
  parameter int HALF = 3
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // count clock toward the timer
  output logic      osc_tick_256hz,
  // request from the timer
  input  wire logic tick_irq,
  output int        irq_seen
);
  logic irq_d_r;

  initial osc_tick_256hz = 1'b0;

  // count clock idles low between bursts
  task automatic pulse(input int n);
    repeat (n)
    begin
      osc_tick_256hz <= 1'b1;
      repeat (HALF) @(posedge aclk);
      osc_tick_256hz <= 1'b0;
      repeat (HALF) @(posedge aclk);
    end
  endtask

  // controller counts each new request
  always_ff @(posedge aclk)
  begin
    irq_d_r <= aresetn & tick_irq;
    if (!aresetn)
      irq_seen <= 0;
    else if (tick_irq && !irq_d_r)
      irq_seen <= irq_seen + 1;
  end
endmodule

// [tb/ptt_timer_tb.sv]
// self-checking bench of the periodic tick timer
`timescale 1ns/1ps
module ptt_timer_tb import ptt_pkg::*;;
  localparam logic [7:0] A_CTL = 8'h00;
  localparam logic [7:0] A_CNT = 8'h04;
  localparam logic [7:0] A_EN  = 8'h08;
  localparam logic [7:0] A_FLG = 8'h0C;
  localparam int         CEIL  = 6000;

  logic        aclk, aresetn, osc, tick_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          irq_seen, errors, checks, cycles;

  ptt_timer dut (
    .aclk(aclk), .aresetn(aresetn), .osc_tick_256hz(osc),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tick_irq(tick_irq)
  );

  ptt_osc_irq_model #(.HALF(3)) u_m (
    .aclk(aclk), .aresetn(aresetn), .osc_tick_256hz(osc), .tick_irq(tick_irq), .irq_seen(irq_seen)
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      errors++;
      $display("unexpected timeout expected done seen hang");
      conclude;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, resp);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, resp);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    chk(what, exp, d);
  endtask

  task automatic t_reset;
    rchk("ctl", A_CTL, 32'h0);
    rchk("cnt", A_CNT, 32'h0);
    rchk("en", A_EN, 32'h0);
    rchk("flg", A_FLG, 32'h0);
    chk("irq", 32'h0, {31'h0, tick_irq});
    $display("t_reset done");
  endtask

  task automatic t_start;
    wok(A_FLG, 32'hF);
    wok(A_CTL, 32'h11);
    u_m.pulse(5);
    rchk("cnt", A_CNT, 32'h4);
    rchk("ctl", A_CTL, 32'h1);
    $display("t_start done");
  endtask

  task automatic t_stop;
    wok(A_CTL, 32'h0);
    u_m.pulse(1);
    rchk("ctl", A_CTL, 32'h1);
    u_m.pulse(1);
    rchk("ctl", A_CTL, 32'h0);
    rchk("cnt", A_CNT, 32'h6);
    u_m.pulse(3);
    rchk("cnt", A_CNT, 32'h6);
    wok(A_CTL, 32'h1);
    u_m.pulse(3);
    rchk("cnt", A_CNT, 32'h8);
    $display("t_stop done");
  endtask

  task automatic t_clear;
    wok(A_CTL, 32'h11);
    rchk("cnt", A_CNT, 32'h0);
    u_m.pulse(2);
    rchk("cnt", A_CNT, 32'h2);
    wok(A_CTL, 32'h0);
    u_m.pulse(2);
    wok(A_CTL, 32'h0);
    rchk("cnt", A_CNT, 32'h4);
    wok(A_CTL, 32'h10);
    u_m.pulse(2);
    rchk("cnt", A_CNT, 32'h0);
    rchk("ctl", A_CTL, 32'h0);
    $display("t_clear done");
  endtask

  task automatic t_flags;
    wok(A_FLG, 32'hF);
    rchk("flg", A_FLG, 32'h0);
    wok(A_CTL, 32'h1);
    u_m.pulse(9);
    rchk("cnt", A_CNT, 32'h8);
    rchk("flg", A_FLG, 32'h1 << FLG_32_BIT);
    chk("irq_seen", 32'h0, 32'(irq_seen));
    wok(A_EN, 32'h1 << FLG_32_BIT);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, tick_irq});
    rchk("en", A_EN, 32'h8);
    wok(A_FLG, 32'h8);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, tick_irq});
    u_m.pulse(248);
    rchk("cnt", A_CNT, 32'h0);
    rchk("flg", A_FLG, 32'hF);
    chk("irq_seen", 32'h2, 32'(irq_seen));
    wok(A_EN, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, tick_irq});
    wok(A_CTL, 32'h0);
    u_m.pulse(2);
    wok(A_FLG, 32'hF);
    rchk("flg", A_FLG, 32'h0);
    $display("t_flags done");
  endtask

  task automatic t_bus;
    logic [31:0] d;
    wr(8'h40, 32'h1, resp);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd(8'h44, d, resp);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("rdata", 32'h0, d);
    rchk("ctl", A_CTL, 32'h0);
    // low byte lane off: the write is dropped but still answered
    wstrb <= 4'hE;
    wok(A_EN, 32'hF);
    wstrb <= 4'hF;
    rchk("en", A_EN, 32'h0);
    // protection bits carry no meaning here
    awprot <= 3'h7;
    arprot <= 3'h7;
    wok(A_CNT, 32'h55);
    rchk("cnt", A_CNT, 32'h2);
    awprot <= 3'h0;
    arprot <= 3'h0;
    $display("t_bus done");
  endtask

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    awprot = 3'h0;
    arprot = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_start;
    t_stop;
    t_clear;
    t_flags;
    t_bus;
    conclude;
  end
endmodule
